// >>> common/serial_if_defines.vh
// constants for the two-wire serial configuration block
`ifndef SERIAL_IF_DEFINES_VH
`define SERIAL_IF_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL_TRANSFER_CLOCK 32'hfffff250
`define IDX_DATA 32'hfffff252
`define IDX_CTRL_MODE 32'hfffff253
`define IDX_CTRL_ENABLE 32'hfffff257

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EN_BIT 7
`define LEN_MSB 7
`define LEN_LSB 5
`define ACK_BIT 4
`define ONE_BIT 3
`define DIV_MSB 2
`define DIV_LSB 0
`define MODE_MSB 3
`define MODE_LSB 2
`define SWRST_MSB 1
`define SWRST_LSB 0
`define BUSY_BIT 7

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define EN_RESET 1'h0
`define LEN_RESET 3'h0
`define ACK_RESET 1'h0
`define DIV_RESET 3'h1
`define MODE_RESET 2'h0
`define MODE_PORT 2'h0
`define MODE_SHIFT 2'h1
`define MODE_I2C 2'h2
`define SWRST_FIRST 2'h2
`define SWRST_SECOND 2'h1
`define DIV_RESERVED 3'h7
`define DIV_BASE_EXP 4'h5
`define DIV_OFFSET 12'h046

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 4000
`define SWRST_TIME_NS 16
`define SWRST_CYCLES (((`SWRST_TIME_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// >>> logic/serial_if_config.v
// two-wire serial interface: configuration registers and bus engine
`timescale 1ns/1ps
`default_nettype none
`include "serial_if_defines.vh"

// What this block does
// - length code sets bits, plus ack clock
// - divider code sets scl half period
// - bit zero: divider write, reset monitor read
// - divider low bit resets one, zero in shift
module serial_if_config (
    input wire CLK,
    input wire RESETN,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output reg [31:0] HRDATA,
    output wire HRESP,
    input wire SCL_I,
    output wire SCL_O,
    output wire SCL_OE_N,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE_N
);

    // ------------------------------------------------------------
    // local encodings
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_LOW = 3'h2;
    localparam [2:0] ST_HIGH = 3'h3;
    localparam [2:0] ST_STOP_LOW = 3'h4;
    localparam [2:0] ST_STOP_HIGH = 3'h5;
    localparam integer SWRST_CYC = `SWRST_CYCLES;
    localparam [3:0] SWRST_COUNT = SWRST_CYC[3:0];

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // byte address of a register index, upper index bits fall off
    function [31:0] reg_addr;
        input [31:0] idx;
        begin
            reg_addr = {idx[29:0], 2'h0};
        end
    endfunction

    // clocks per transfer: code 0 means eight data bits
    function [3:0] clocks_per_transfer;
        input [2:0] len;
        input ack;
        begin
            clocks_per_transfer = ((len == 3'h0) ? 4'h8 : {1'h0, len})
                + {3'h0, ack};
        end
    endfunction

    // scl half period in system clocks: 2^n + 70, n = code + 5, reserved code 7 taken as 6
    function [11:0] half_period;
        input [2:0] code;
        reg [2:0] c;
        begin
            c = (code == `DIV_RESERVED) ? 3'h6 : code;
            half_period = (12'h001 << ({1'h0, c} + `DIV_BASE_EXP))
                + `DIV_OFFSET;
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg enable_q; // block_enable
    reg [2:0] len_q; // transfer_length_sel
    reg ack_q; // acknowledge clock on
    reg [2:0] div_q; // scl_divider_sel, bit 0 is divider_low_bit
    reg [1:0] mode_q; // serial_ctrl_mode operating mode
    reg swrst_armed_q; // first half of reset key seen
    reg [3:0] swrst_cnt_q; // nonzero while soft reset runs
    reg [7:0] tx_q; // byte to send
    reg [7:0] rx_q; // byte received
    reg [2:0] state_q;
    reg [11:0] timer_q; // half period countdown
    reg [3:0] bit_q; // clocks done in this transfer
    reg scl_drive_q; // pulls scl low when set
    reg sda_drive_q; // pulls sda low when set
    reg scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q; // pin synchronisers
    reg wr_pend_q; // write data phase pending
    reg [31:0] wr_addr_q; // address of pending write

    wire busy = (state_q != ST_IDLE);
    wire swrst_busy = (swrst_cnt_q != 4'h0);
    wire [3:0] total = clocks_per_transfer(len_q, ack_q);
    wire addr_phase = HSEL && HREADY && HTRANS[1];
    wire wr_data = wr_pend_q;
    wire [7:0] wbyte = HWDATA[7:0];
    wire timer_done = (timer_q == 12'h000);

    // every access finishes with no wait state and an OKAY answer
    assign HREADYOUT = 1'h1;
    assign HRESP = 1'h0;

    // open drain: only ever drive low, enable is active low
    assign SCL_O = 1'h0;
    assign SDA_O = 1'h0;
    assign SCL_OE_N = ~scl_drive_q;
    assign SDA_OE_N = ~sda_drive_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two flops before anything looks at the bus lines
    always @(posedge CLK) begin
        if (!RESETN) begin
            scl_s1_q <= 1'h1;
            scl_s2_q <= 1'h1;
            sda_s1_q <= 1'h1;
            sda_s2_q <= 1'h1;
        end else begin
            scl_s1_q <= SCL_I;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= SDA_I;
            sda_s2_q <= sda_s1_q;
        end
    end

    // ------------------------------------------------------------
    // bus slave: address capture and read data
    // ------------------------------------------------------------
    // read data is registered at the address phase, so it stands
    // through the whole data phase
    always @(posedge CLK) begin
        if (!RESETN) begin
            wr_pend_q <= 1'h0;
            wr_addr_q <= 32'h00000000;
            HRDATA <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_phase && HWRITE;
            if (addr_phase) begin
                wr_addr_q <= HADDR;
            end
            if (addr_phase && !HWRITE) begin
                if (HADDR == reg_addr(`IDX_CTRL_ENABLE)) begin
                    HRDATA <= {24'h000000, enable_q, 7'h00};
                end else if (HADDR == reg_addr(`IDX_CTRL_TRANSFER_CLOCK)) begin
                    HRDATA <= {24'h000000, len_q, ack_q, 1'h1,
                        div_q[2], 1'h0, ~swrst_busy};
                end else if (HADDR == reg_addr(`IDX_DATA)) begin
                    HRDATA <= {24'h000000, rx_q};
                end else if (HADDR == reg_addr(`IDX_CTRL_MODE)) begin
                    HRDATA <= {24'h000000, busy, 3'h0, mode_q, 2'h0};
                end else begin
                    // unmapped addresses read as zero
                    HRDATA <= 32'h00000000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // writes land in the data phase, one cycle after the address
    always @(posedge CLK) begin
        if (!RESETN) begin
            enable_q <= `EN_RESET;
            len_q <= `LEN_RESET;
            ack_q <= `ACK_RESET;
            div_q <= `DIV_RESET;
            mode_q <= `MODE_RESET;
            swrst_armed_q <= 1'h0;
            swrst_cnt_q <= 4'h0;
            tx_q <= 8'h00;
        end else begin
            if (swrst_busy) begin
                swrst_cnt_q <= swrst_cnt_q - 4'h1;
            end
            if (wr_data) begin
                if (wr_addr_q == reg_addr(`IDX_CTRL_ENABLE)) begin
                    enable_q <= wbyte[`EN_BIT];
                end else if (wr_addr_q ==
                    reg_addr(`IDX_CTRL_TRANSFER_CLOCK)) begin
                    len_q <= wbyte[`LEN_MSB:`LEN_LSB];
                    ack_q <= wbyte[`ACK_BIT];
                    div_q <= wbyte[`DIV_MSB:`DIV_LSB];
                end else if (wr_addr_q == reg_addr(`IDX_DATA)) begin
                    // a transfer in flight keeps its byte
                    if (!busy) begin
                        tx_q <= wbyte;
                    end
                end else if (wr_addr_q == reg_addr(`IDX_CTRL_MODE)) begin
                    mode_q <= wbyte[`MODE_MSB:`MODE_LSB];
                    if (wbyte[`MODE_MSB:`MODE_LSB] == `MODE_SHIFT) begin
                        div_q[0] <= 1'h0;
                    end
                    // reset key: 10 then 01 starts the soft reset
                    if (wbyte[`SWRST_MSB:`SWRST_LSB] == `SWRST_FIRST) begin
                        swrst_armed_q <= 1'h1;
                    end else if (wbyte[`SWRST_MSB:`SWRST_LSB] ==
                        `SWRST_SECOND && swrst_armed_q) begin
                        swrst_armed_q <= 1'h0;
                        swrst_cnt_q <= SWRST_COUNT;
                    end else begin
                        swrst_armed_q <= 1'h0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    // a write to the data register starts one framed transfer when
    // the block is enabled in bus mode; soft reset or disabling the
    // block abandons the frame and releases both lines at once
    always @(posedge CLK) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            timer_q <= 12'h000;
            bit_q <= 4'h0;
            rx_q <= 8'h00;
            scl_drive_q <= 1'h0;
            sda_drive_q <= 1'h0;
        end else if (swrst_busy || !enable_q || mode_q != `MODE_I2C) begin
            state_q <= ST_IDLE;
            scl_drive_q <= 1'h0;
            sda_drive_q <= 1'h0;
        end else begin
            if (!timer_done) begin
                timer_q <= timer_q - 12'h001;
            end
            case (state_q)
                ST_IDLE: begin
                    if (wr_data && wr_addr_q == reg_addr(`IDX_DATA)) begin
                        sda_drive_q <= 1'h1;
                        bit_q <= 4'h0;
                        timer_q <= half_period(div_q);
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (timer_done) begin
                        scl_drive_q <= 1'h1;
                        timer_q <= half_period(div_q);
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // data bits msb first, ack clock leaves sda free
                    if (bit_q < clocks_per_transfer(len_q, 1'h0)) begin
                        sda_drive_q <= ~tx_q[3'h7 - bit_q[2:0]];
                    end else begin
                        sda_drive_q <= 1'h0;
                    end
                    if (timer_done) begin
                        scl_drive_q <= 1'h0;
                        timer_q <= half_period(div_q);
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    // a slave holding scl low stretches the high phase
                    if (!scl_s2_q) begin
                        timer_q <= half_period(div_q);
                    end else if (timer_done) begin
                        if (bit_q < clocks_per_transfer(len_q, 1'h0)) begin
                            rx_q <= {rx_q[6:0], sda_s2_q};
                        end
                        scl_drive_q <= 1'h1;
                        timer_q <= half_period(div_q);
                        bit_q <= bit_q + 4'h1;
                        if (bit_q + 4'h1 == total) begin
                            state_q <= ST_STOP_LOW;
                        end else begin
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_STOP_LOW: begin
                    sda_drive_q <= 1'h1;
                    if (timer_done) begin
                        scl_drive_q <= 1'h0;
                        timer_q <= half_period(div_q);
                        state_q <= ST_STOP_HIGH;
                    end
                end
                ST_STOP_HIGH: begin
                    if (timer_done && scl_s2_q) begin
                        sda_drive_q <= 1'h0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // serial_if_config
`default_nettype wire

// >>> sim/serial_if_config_assertions.sv
// port checker for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
`include "serial_if_defines.vh"
module serial_if_config_assertions (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic [31:0] HRDATA,
    input wire logic HRESP,
    input wire logic SCL_O,
    input wire logic SCL_OE_N,
    input wire logic SDA_O,
    input wire logic SDA_OE_N
);
    localparam logic [31:0] A_EN = `IDX_CTRL_ENABLE * 32'h4;
    localparam logic [31:0] A_TC = `IDX_CTRL_TRANSFER_CLOCK * 32'h4;
    logic en_q; // mirror of block_enable
    logic wen_q; // enable write now in its data phase
    logic sda_p_q; // sda enable one cycle ago
    logic scl_p_q; // scl enable one cycle ago
    logic [11:0] gap_q; // cycles since start with scl still free
    wire logic take = HSEL && HREADY && HTRANS[1];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // mirror lands at the end of the data phase, like the register
    always @(posedge CLK) begin
        if (!RESETN) begin
            en_q <= 1'b0;
            wen_q <= 1'b0;
        end else begin
            wen_q <= take && HWRITE && HADDR == A_EN;
            if (wen_q) en_q <= HWDATA[7];
        end
    end
    // wait from a start to the first clock fall; the longest half
    // period is too long for a delay range, so count it here
    always @(posedge CLK) begin
        if (!RESETN) begin
            sda_p_q <= 1'b1;
            scl_p_q <= 1'b1;
            gap_q <= 12'h000;
        end else begin
            sda_p_q <= SDA_OE_N;
            scl_p_q <= SCL_OE_N;
            if (sda_p_q && !SDA_OE_N && scl_p_q && SCL_OE_N)
                gap_q <= 12'h001;
            else if (gap_q != 12'h000 && SCL_OE_N && en_q)
                gap_q <= gap_q + 12'h001;
            else
                gap_q <= 12'h000;
        end
    end
    sequence rd_at(logic [31:0] a);
        take && !HWRITE && HADDR == a;
    endsequence
    sequence start_cond;
        $fell(SDA_OE_N) && SCL_OE_N && $past(SCL_OE_N);
    endsequence
    bus_okay_a:
        assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    open_drain_a:
        assert property (!SCL_O && !SDA_O)
        else $error("line driven high");
    reset_idle_a:
        assert property ($rose(RESETN) |-> SCL_OE_N && SDA_OE_N)
        else $error("lines held after reset");
    enable_read_a:
        assert property (rd_at(A_EN) |=> HRDATA == {24'h0, $past(en_q), 7'h0})
        else $error("enable register read wrong");
    clock_read_a:
        assert property (rd_at(A_TC) |=> HRDATA[3] && !HRDATA[1])
        else $error("transfer clock fixed bits wrong");
    start_hold_a:
        assert property (start_cond |=> SCL_OE_N [*8])
        else $error("scl pulled too soon after start");
    start_clock_a:
        assert property (gap_q <= 12'h898)
        else $error("no clock after start");
    low_min_a:
        assert property ($fell(SCL_OE_N) |=> (!SCL_OE_N || !en_q) [*8])
        else $error("scl low phase too short");
    idle_off_a:
        assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
            |-> SCL_OE_N && SDA_OE_N)
        else $error("lines held while disabled");
endmodule // serial_if_config_assertions
`default_nettype wire

// >>> sim/serial_slave_model.sv
// far-side bus device: acknowledges and may stretch the clock
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic scl_pull,
    output logic sda_pull
);
    logic [3:0] cnt_q = 4'hf; // clock falls since start, f when idle
    logic [9:0] hold_q = 10'h0; // stretch cycles left
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // start resets count, stop parks it
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda)
            cnt_q <= 4'h0;
        else if (scl && scl_q && !sda_q && sda)
            cnt_q <= 4'hf;
        else if (scl_q && !scl && cnt_q != 4'hf)
            cnt_q <= cnt_q + 4'h1;
        hold_q <= (scl_q && !scl && stretch) ? 10'h190
            : hold_q - {9'h0, hold_q != 10'h0};
    end
    assign sda_pull = cnt_q == 4'h9;
    // stretch far beyond the half period, so the wait is real
    assign scl_pull = hold_q != 10'h0;
endmodule // serial_slave_model
`default_nettype wire

// >>> sim/serial_if_config_bench.sv
// self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
`include "serial_if_defines.vh"
module serial_if_config_bench;
    localparam logic [31:0] A_TC = `IDX_CTRL_TRANSFER_CLOCK * 32'h4;
    localparam logic [31:0] A_DAT = `IDX_DATA * 32'h4;
    localparam logic [31:0] A_MOD = `IDX_CTRL_MODE * 32'h4;
    localparam logic [31:0] A_EN = `IDX_CTRL_ENABLE * 32'h4;
    localparam int H = (1 << `DIV_BASE_EXP) + `DIV_OFFSET; // code 000
    logic clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, stretch = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire logic hready, scl_oe_n, sda_oe_n, scl_pull, sda_pull;
    wire logic [31:0] hrdata;
    wire logic scl = scl_oe_n && !scl_pull; // pulled-up lines
    wire logic sda = sda_oe_n && !sda_pull;
    int failures = 0, n_tests = 0, nfall = 0, hi = 0, hlast = 0;
    logic scl_p = 1'b1;
    logic [9:0] rx = 10'h0; // bits sampled at scl rises
    logic [7:0] v;
    initial forever #2 clk = ~clk;
    serial_if_config dut (.CLK(clk), .RESETN(resetn), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
        .HRDATA(hrdata), .HRESP(), .SCL_I(scl), .SCL_O(),
        .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n));
    serial_slave_model far (.clk(clk), .scl(scl), .sda(sda),
        .stretch(stretch), .scl_pull(scl_pull), .sda_pull(sda_pull));
    // line watcher: clock falls, last high time, sampled bits
    always @(posedge clk) begin
        scl_p <= scl;
        hi <= scl ? hi + 1 : 0;
        if (scl && !scl_p) rx <= {rx[8:0], sda};
        if (!scl && scl_p) begin
            nfall <= nfall + 1;
            hlast <= hi;
        end
    end
    task conclude;
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask
    // one bus phase; hready is waited for, never assumed
    task step;
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            if (++k > 50) begin
                bad("bus hang");
                conclude;
            end
            @(posedge clk);
        end
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        step;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        step;
    endtask
    task rd(input logic [31:0] a);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        step;
        htrans <= 2'h0;
        step;
        v = hrdata[7:0];
    endtask
    task chk(input logic [31:0] a, input logic [7:0] e);
        rd(a);
        n_tests++;
        if (v !== e) bad($sformatf("read %h got %h want %h", a, v, e));
    endtask
    // one frame; busy is polled with a bound
    task xfer(input logic [7:0] tc, input logic [7:0] d, input int nclk,
              input logic [9:0] bits);
        int k;
        k = 0;
        wr(A_TC, tc);
        nfall <= 0;
        rx <= 10'h0;
        wr(A_DAT, d);
        v = 8'h80;
        while (v[7]) begin
            if (++k > 3000) begin
                bad("busy stuck");
                conclude;
            end
            rd(A_MOD);
        end
        n_tests++;
        if (nfall !== nclk + 1 || rx !== bits) bad("frame shape");
        n_tests++;
        if (hlast < H || hlast > H + 3) bad("scl half period");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk(A_EN, 8'h00);
        chk(A_TC, 8'h09);
        chk(32'h0, 8'h00);
        wr(A_EN, 8'hff);
        chk(A_EN, 8'h80);
        for (int i = 0; i < 8; i++) begin
            wr(A_TC, {i[2:0], i[0], i[1] ? 4'hf : 4'h0});
            chk(A_TC, {i[2:0], i[0], i[1] ? 4'hd : 4'h9});
        end
        wr(A_MOD, 8'h0a);
        wr(A_MOD, 8'h09);
        chk(A_TC, 8'hfc);
        repeat (8) @(posedge clk);
        chk(A_TC, 8'hfd);
        xfer(8'h10, 8'ha5, 9, 10'h294);
        stretch <= 1'b1;
        xfer(8'h60, 8'hc3, 3, 10'h00c);
        stretch <= 1'b0;
        wr(A_TC, 8'h01);
        wr(A_MOD, 8'h04);
        wr(A_MOD, 8'h08);
        wr(A_DAT, 8'hff);
        repeat (340) @(posedge clk);
        n_tests++;
        if (hlast < H || hlast > H + 3) bad("low bit kept");
        wr(A_EN, 8'h00);
        repeat (4) @(posedge clk);
        n_tests++;
        if (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1) bad("lines held");
        chk(A_MOD, 8'h08);
        conclude;
    end
endmodule // serial_if_config_bench
bind serial_if_config serial_if_config_assertions watch (.CLK(CLK),
    .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .SCL_O(SCL_O), .SCL_OE_N(SCL_OE_N), .SDA_O(SDA_O),
    .SDA_OE_N(SDA_OE_N));
`default_nettype wire
